// ### rtl/sgm_pkg.sv
package sgm_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_SRC = 4'h4;
	localparam logic [3:0] OFS_CARH = 4'h8;
	localparam logic [3:0] OFS_CARL = 4'hc;

	// ----------------------------------------
	// modulation_control fields
	// ----------------------------------------
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OE_BIT = 6;
	localparam int CTRL_SLR_BIT = 5;
	localparam int CTRL_OPOL_BIT = 4;
	localparam int CTRL_OUT_BIT = 3;
	localparam int CTRL_SWBIT_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h20;
	localparam logic [7:0] CTRL_WMASK = 8'hf1;

	// ----------------------------------------
	// source and carrier control fields
	// ----------------------------------------
	localparam int ODIS_BIT = 7;
	localparam int CAR_POL_BIT = 6;
	localparam int CAR_SYNC_BIT = 5;
	localparam int SEL_MSB = 3;
	localparam logic [7:0] SRC_RST = 8'h00;
	localparam logic [7:0] SRC_WMASK = 8'h8f;
	localparam logic [7:0] CAR_RST = 8'h00;
	localparam logic [7:0] CAR_WMASK = 8'hef;

	// ----------------------------------------
	// source codes
	// ----------------------------------------
	localparam logic [3:0] MS_SWBIT = 4'h0;
	localparam logic [3:0] MS_PIN = 4'h1;
	localparam logic [3:0] MS_PWM1 = 4'h2;
	localparam logic [3:0] MS_CMP1 = 4'h6;
	localparam logic [3:0] MS_SPI1 = 4'h8;
	localparam logic [3:0] MS_UART = 4'ha;
	localparam logic [3:0] CS_GND = 4'h0;
	localparam logic [3:0] CS_PIN1 = 4'h1;
	localparam logic [3:0] CS_PIN2 = 4'h2;
	localparam logic [3:0] CS_REFCLK = 4'h3;
	localparam logic [3:0] CS_PWM1 = 4'h4;

endpackage

// ### rtl/sgm_sync.sv
`timescale 1ns/10ps
`default_nettype none

module sgm_sync #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			q <= '0;
		end
		else if (ce)
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule

`default_nettype wire

// ### rtl/sgm_top.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module sgm_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sgm_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic modulator_input_pin,
	input wire logic carrier_input_pin_one,
	input wire logic carrier_input_pin_two,
	input wire logic [3:0] pwm_out,
	input wire logic [1:0] comparator_out,
	input wire logic [1:0] spi_data_out,
	input wire logic uart_tx,
	input wire logic reference_clock_output,
	output logic modulated_output,
	output logic slew_limit_en,
	output logic [3:0] pwm_pin_drive_disable,
	output logic [1:0] comparator_pin_drive_disable,
	output logic [1:0] spi_pin_drive_disable,
	output logic uart_pin_drive_disable,
	output logic refclk_pin_drive_disable
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] pins_s;

	sgm_sync #(
		.W(3)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.ce(clk_en),
		.d({carrier_input_pin_two, carrier_input_pin_one, modulator_input_pin}),
		.q(pins_s)
	);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] ctrl_r;
	logic [7:0] src_r;
	logic [7:0] carh_r;
	logic [7:0] carl_r;
	logic status_r;
	logic armed_r;
	logic access_c;
	logic hit_c;
	logic wr_ctrl_c;
	logic [7:0] wbyte_c;
	logic [7:0] rd_c;

	assign access_c = psel && penable && clk_en && armed_r;
	assign hit_c = (paddr == sgm_pkg::OFS_CTRL) || (paddr == sgm_pkg::OFS_SRC)
		|| (paddr == sgm_pkg::OFS_CARH) || (paddr == sgm_pkg::OFS_CARL);
	assign wbyte_c = pwdata[7:0];
	assign wr_ctrl_c = access_c && pwrite && (paddr == sgm_pkg::OFS_CTRL);
	// a transfer whose setup edge was frozen waits a cycle for its read data
	assign pready = clk_en && (armed_r || !penable);
	assign pslverr = psel && penable && !hit_c;

	// reset returns every register to its default
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= sgm_pkg::CTRL_RST;
			src_r <= sgm_pkg::SRC_RST;
			carh_r <= sgm_pkg::CAR_RST;
			carl_r <= sgm_pkg::CAR_RST;
		end
		else if (access_c && pwrite)
		begin
			// selections live in their own registers, untouched by enable
			unique case (paddr)
				sgm_pkg::OFS_CTRL: ctrl_r <= wbyte_c & sgm_pkg::CTRL_WMASK;
				sgm_pkg::OFS_SRC: src_r <= wbyte_c & sgm_pkg::SRC_WMASK;
				sgm_pkg::OFS_CARH: carh_r <= wbyte_c & sgm_pkg::CAR_WMASK;
				sgm_pkg::OFS_CARL: carl_r <= wbyte_c & sgm_pkg::CAR_WMASK;
				default: ;
			endcase
		end
	end

	always_comb
	begin
		rd_c = 8'h00;
		unique case (paddr)
			sgm_pkg::OFS_CTRL:
			begin
				rd_c = ctrl_r;
				rd_c[sgm_pkg::CTRL_OUT_BIT] = status_r;
			end
			sgm_pkg::OFS_SRC: rd_c = src_r;
			sgm_pkg::OFS_CARH: rd_c = carh_r;
			sgm_pkg::OFS_CARL: rd_c = carl_r;
			default: rd_c = 8'h00;
		endcase
	end

	// set once read data is loaded for the transfer, cleared as it completes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			armed_r <= 1'b0;
		else if (clk_en)
			armed_r <= psel && !(penable && armed_r);
	end

	// read data captured once per transfer so it stands through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && psel && !armed_r)
			prdata <= {24'h00_0000, rd_c};
	end

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	logic en_c;
	logic oe_c;
	logic opol_c;
	logic swbit_c;
	logic [3:0] ms_c;
	logic [3:0] ch_c;
	logic [3:0] cl_c;
	logic hsync_c;
	logic lsync_c;

	assign en_c = ctrl_r[sgm_pkg::CTRL_EN_BIT];
	assign oe_c = ctrl_r[sgm_pkg::CTRL_OE_BIT];
	assign opol_c = ctrl_r[sgm_pkg::CTRL_OPOL_BIT];
	assign swbit_c = ctrl_r[sgm_pkg::CTRL_SWBIT_BIT];
	assign ms_c = src_r[sgm_pkg::SEL_MSB:0];
	assign ch_c = carh_r[sgm_pkg::SEL_MSB:0];
	assign cl_c = carl_r[sgm_pkg::SEL_MSB:0];
	assign hsync_c = carh_r[sgm_pkg::CAR_SYNC_BIT];
	assign lsync_c = carl_r[sgm_pkg::CAR_SYNC_BIT];

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	logic mod_c;
	logic carh_raw_c;
	logic carl_raw_c;
	logic carh_c;
	logic carl_c;

	// disabled module falls back to software bit and ground carriers
	always_comb
	begin
		mod_c = 1'b0;
		if (!en_c)
			mod_c = swbit_c;
		else
		begin
			unique case (ms_c)
				4'h0: mod_c = swbit_c;
				4'h1: mod_c = pins_s[0];
				4'h2, 4'h3, 4'h4, 4'h5: mod_c = pwm_out[ms_c[1:0] - 2'd2];
				4'h6, 4'h7: mod_c = comparator_out[ms_c[0]];
				4'h8, 4'h9: mod_c = spi_data_out[ms_c[0]];
				4'ha: mod_c = uart_tx;
				default: mod_c = 1'b0;
			endcase
		end
	end

	function automatic logic car_pick(input logic [3:0] sel, input logic [2:0] pins,
		input logic refclk, input logic [3:0] pwm);
		logic v;
		v = 1'b0;
		unique case (sel)
			4'h0: v = 1'b0;
			4'h1: v = pins[1];
			4'h2: v = pins[2];
			4'h3: v = refclk;
			4'h4, 4'h5, 4'h6, 4'h7: v = pwm[sel[1:0]];
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	assign carh_raw_c = en_c && car_pick(ch_c, pins_s, reference_clock_output, pwm_out);
	assign carl_raw_c = en_c && car_pick(cl_c, pins_s, reference_clock_output, pwm_out);
	// polarity after grounding keeps a disabled inverted carrier high
	assign carh_c = carh_raw_c ^ carh_r[sgm_pkg::CAR_POL_BIT];
	assign carl_c = carl_raw_c ^ carl_r[sgm_pkg::CAR_POL_BIT];

	// ----------------------------------------
	// carrier switching and mixing
	// ----------------------------------------
	logic held_high_r;
	logic hold_c;
	logic use_high_c;
	logic mixed_c;
	logic out_inv_c;

	// a synced carrier still high blocks the switch until it falls
	assign hold_c = held_high_r ? (hsync_c && carh_c) : (lsync_c && carl_c);
	assign use_high_c = (mod_c != held_high_r && hold_c) ? held_high_r : mod_c;
	assign mixed_c = use_high_c ? carh_c : carl_c;
	assign out_inv_c = mixed_c ^ opol_c;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			held_high_r <= 1'b0;
		else if (clk_en)
			held_high_r <= use_high_c;
	end

	// no sleep input: logic runs whenever clk_en is high and its clock and sources run
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			modulated_output <= 1'b0;
			status_r <= 1'b0;
			slew_limit_en <= 1'b1;
		end
		else if (clk_en)
		begin
			modulated_output <= oe_c && out_inv_c;
			status_r <= out_inv_c;
			slew_limit_en <= ctrl_r[sgm_pkg::CTRL_SLR_BIT];
		end
	end

	// ----------------------------------------
	// peripheral pin drive disables
	// ----------------------------------------
	logic mdis_c;
	logic hdis_c;
	logic ldis_c;
	logic [3:0] pwm_dis_c;

	assign mdis_c = en_c && src_r[sgm_pkg::ODIS_BIT];
	assign hdis_c = en_c && carh_r[sgm_pkg::ODIS_BIT];
	assign ldis_c = en_c && carl_r[sgm_pkg::ODIS_BIT];

	generate
		for (genvar i = 0; i < 4; i++)
		begin : g_pwm
			assign pwm_dis_c[i] = (mdis_c && ms_c == sgm_pkg::MS_PWM1 + 4'(i))
				|| (hdis_c && ch_c == sgm_pkg::CS_PWM1 + 4'(i))
				|| (ldis_c && cl_c == sgm_pkg::CS_PWM1 + 4'(i));
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwm_pin_drive_disable <= 4'h0;
			comparator_pin_drive_disable <= 2'h0;
			spi_pin_drive_disable <= 2'h0;
			uart_pin_drive_disable <= 1'b0;
			refclk_pin_drive_disable <= 1'b0;
		end
		else if (clk_en)
		begin
			pwm_pin_drive_disable <= pwm_dis_c;
			comparator_pin_drive_disable <= {mdis_c && ms_c == sgm_pkg::MS_CMP1 + 4'h1,
				mdis_c && ms_c == sgm_pkg::MS_CMP1};
			spi_pin_drive_disable <= {mdis_c && ms_c == sgm_pkg::MS_SPI1 + 4'h1,
				mdis_c && ms_c == sgm_pkg::MS_SPI1};
			uart_pin_drive_disable <= mdis_c && ms_c == sgm_pkg::MS_UART;
			refclk_pin_drive_disable <= (hdis_c && ch_c == sgm_pkg::CS_REFCLK)
				|| (ldis_c && cl_c == sgm_pkg::CS_REFCLK);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_pin_held_low: assert property (clk_en && !oe_c |=> !modulated_output)
		else $error("output pin not low while pin enable is clear");
	a_disabled_ground: assert property (clk_en && !en_c && oe_c && !opol_c
		&& !carh_r[sgm_pkg::CAR_POL_BIT] && !carl_r[sgm_pkg::CAR_POL_BIT]
		|=> !modulated_output)
		else $error("disabled module produced a carrier");
	a_sw_select: assert property (clk_en && en_c && oe_c && !opol_c
		&& !hsync_c && !lsync_c && ms_c == sgm_pkg::MS_SWBIT
		|=> modulated_output == $past(swbit_c ? carh_c : carl_c))
		else $error("software bit picked the wrong carrier");
	a_out_invert: assert property (clk_en && en_c && oe_c && opol_c && !hsync_c
		&& ms_c == sgm_pkg::MS_SWBIT && !swbit_c && cl_c == sgm_pkg::CS_GND
		&& !carl_r[sgm_pkg::CAR_POL_BIT] && !lsync_c |=> modulated_output)
		else $error("output inversion not applied");
	a_status_match: assert property (clk_en && oe_c |=> modulated_output == status_r)
		else $error("status bit differs from output");
	a_sync_hold: assert property (clk_en && en_c && oe_c && !opol_c && held_high_r
		&& hsync_c && carh_c && !mod_c |=> modulated_output)
		else $error("synced high carrier cut mid-pulse");
	a_nosync_switch: assert property (clk_en && oe_c && !opol_c && !hsync_c
		&& held_high_r && !mod_c |=> modulated_output == $past(carl_c))
		else $error("unsynced carrier did not switch at once");
	a_reset_values: assert property (!$past(presetn) |-> slew_limit_en
		&& !modulated_output && ctrl_r == sgm_pkg::CTRL_RST)
		else $error("reset defaults wrong");
	a_keep_select: assert property (wr_ctrl_c && !wbyte_c[sgm_pkg::CTRL_EN_BIT]
		|=> $stable(src_r) && $stable(carh_r) && $stable(carl_r))
		else $error("disable altered source selections");
	a_pwm_drive: assert property (clk_en && mdis_c && ms_c == sgm_pkg::MS_PWM1
		|=> pwm_pin_drive_disable[0])
		else $error("modulator drive disable missing");

	c_sync_wait: cover property (en_c && held_high_r && hsync_c && carh_c && !mod_c);
	c_pin_mod: cover property (en_c && oe_c && ms_c == sgm_pkg::MS_PIN && modulated_output);
	c_bus_err: cover property (pslverr);
	c_bus_wait: cover property (psel && penable && !pready);

endmodule

`default_nettype wire

// ### bench/sgm_peer.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// on-chip sources and input pins
// ----------------------------------------
module sgm_peer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [12:0] lvl,
	output logic modulator_input_pin,
	output logic carrier_input_pin_one,
	output logic carrier_input_pin_two,
	output logic [3:0] pwm_out,
	output logic [1:0] comparator_out,
	output logic [1:0] spi_data_out,
	output logic uart_tx,
	output logic reference_clock_output
);
	// sources keep toggling on pclk, so nothing stops while the core sleeps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{reference_clock_output, uart_tx, spi_data_out, comparator_out, pwm_out,
				carrier_input_pin_two, carrier_input_pin_one, modulator_input_pin} <= 13'h0000;
		else
			{reference_clock_output, uart_tx, spi_data_out, comparator_out, pwm_out,
				carrier_input_pin_two, carrier_input_pin_one, modulator_input_pin} <= lvl;
	end
endmodule
`default_nettype wire

// ### bench/tb_sgm_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_sgm_top;
	logic pclk, presetn, clk_en, psel, penable, pwrite;
	logic [3:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, er, mi, c1, c2, uart, refc, mout, slew, udd, rdd;
	logic [3:0] pwm, pwmdd;
	logic [1:0] cmp, spi, cmpdd, spidd;
	logic [12:0] lvl;
	logic [7:0] r[4];
	logic [7:0] m[4];
	logic [10:0] e;
	int fails, checks_done;

	sgm_peer sgm_peer_i (.pclk(pclk), .presetn(presetn), .lvl(lvl),
		.modulator_input_pin(mi), .carrier_input_pin_one(c1), .carrier_input_pin_two(c2),
		.pwm_out(pwm), .comparator_out(cmp), .spi_data_out(spi), .uart_tx(uart),
		.reference_clock_output(refc));
	sgm_top sgm_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .modulator_input_pin(mi),
		.carrier_input_pin_one(c1), .carrier_input_pin_two(c2), .pwm_out(pwm),
		.comparator_out(cmp), .spi_data_out(spi), .uart_tx(uart),
		.reference_clock_output(refc), .modulated_output(mout), .slew_limit_en(slew),
		.pwm_pin_drive_disable(pwmdd), .comparator_pin_drive_disable(cmpdd),
		.spi_pin_drive_disable(spidd), .uart_pin_drive_disable(udd),
		.refclk_pin_drive_disable(rdd));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ----------------------------------------
	// expectation: {mix after invert, drive disables}
	// ----------------------------------------
	function automatic logic car(logic [3:0] q, logic [12:0] v);
		case (q)
			4'h1: car = v[1];
			4'h2: car = v[2];
			4'h3: car = v[12];
			4'h4, 4'h5, 4'h6, 4'h7: car = v[q-4'h1];
			default: car = 1'b0;
		endcase
	endfunction

	function automatic logic [10:0] exp_f(logic [7:0] c, logic [7:0] s, logic [7:0] h,
		logic [7:0] l, logic [12:0] v);
		logic [3:0] sel;
		logic md, hc, lc;
		logic [3:0] cc;
		sel = c[7] ? s[3:0] : 4'h0;
		md = (sel == 4'h0) ? c[0] : (sel == 4'h1) ? v[0] : (sel <= 4'ha) ? v[sel+4'h1] : 1'b0;
		hc = car(c[7] ? h[3:0] : 4'h0, v) ^ h[6];
		lc = car(c[7] ? l[3:0] : 4'h0, v) ^ l[6];
		exp_f[10] = (md ? hc : lc) ^ c[4];
		for (int i = 0; i < 10; i++)
		begin
			cc = (i < 4) ? 4'(i + 4) : 4'h3;
			exp_f[i] = c[7] && ((s[7] && i < 9 && s[3:0] == 4'(i + 2)) ||
				((i < 4 || i == 9) && ((h[7] && h[3:0] == cc) || (l[7] && l[3:0] == cc))));
		end
	endfunction

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// the wait ends once pready is seen high; only the watchdog ends one where it never rises
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x)
		begin
			$display("ERROR %s expected %h seen %h", nm, x, g);
			fails++;
		end
	endtask

	task automatic results;
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		fails++;
		results();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{presetn, clk_en, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
		fails = 0;
		checks_done = 0;
		m = '{sgm_pkg::CTRL_WMASK, sgm_pkg::SRC_WMASK, sgm_pkg::CAR_WMASK, sgm_pkg::CAR_WMASK};
		void'($urandom(32'hee21));
		clk_en = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("slew_rst", 1, slew);
		chk("out_rst", 0, mout);
		for (int j = 0; j < 4; j++)
		begin
			apb(1'b0, 4'(j * 4), 8'h00);
			chk("reg_rst", (j == 0) ? 32'h20 : 32'h0, rd);
		end
		apb(1'b0, 4'h2, 8'h00);
		chk("slverr", 1, er);
		chk("unmapped", 0, rd);
		// sync off here: a held synced carrier would make steady-state checks ambiguous
		for (int n = 0; n < 240; n++)
		begin
			r = '{8'($urandom), 8'($urandom), 8'($urandom) & 8'hdf, 8'($urandom) & 8'hdf};
			if (n < 16)
			begin
				r[0][7] = 1'b1;
				r[1][3:0] = 4'(n);
				r[2][3:0] = 4'(n);
				r[3][3:0] = 4'(n);
			end
			if (n == 16)
				r = '{8'hd0, 8'h00, 8'h00, 8'h00};
			if (n == 17)
				r = '{8'h80, 8'h82, 8'h00, 8'h00};
			lvl <= 13'($urandom);
			for (int j = 3; j >= 0; j--)
				apb(1'b1, 4'(j * 4), r[j]);
			repeat (5) @(posedge pclk);
			e = exp_f(r[0], r[1], r[2], r[3], lvl);
			chk("mod_out", e[10] & r[0][6], mout);
			chk("drive_dis", e[9:0], {rdd, udd, spidd, cmpdd, pwmdd});
			chk("slew", r[0][5], slew);
			for (int j = 0; j < 4; j++)
			begin
				apb(1'b0, 4'(j * 4), 8'h00);
				chk("readback", (j == 0) ? {r[0] & m[0]} | {e[10], 3'h0} : r[j] & m[j], rd);
			end
		end
		// 0: no sync, 1: high carrier synced, 2: only low carrier synced
		for (int k = 0; k < 3; k++)
		begin
			lvl <= 13'h0008;
			apb(1'b1, 4'h0, 8'hc1);
			apb(1'b1, 4'h4, 8'h00);
			apb(1'b1, 4'h8, (k == 1) ? 8'h24 : 8'h04);
			apb(1'b1, 4'hc, (k == 2) ? 8'h20 : 8'h00);
			repeat (5) @(posedge pclk);
			chk("sync_on", 1, mout);
			apb(1'b1, 4'h0, 8'hc0);
			repeat (4) @(posedge pclk);
			chk("sync_hold", (k == 1), mout);
			lvl <= 13'h0000;
			repeat (3) @(posedge pclk);
			lvl <= 13'h0008;
			repeat (3) @(posedge pclk);
			chk("sync_low", 0, mout);
		end
		// frozen clock enable, then a read whose setup edge is frozen
		apb(1'b1, 4'h4, 8'h0a);
		lvl <= 13'h0808;
		repeat (4) @(posedge pclk);
		chk("uart_mod", 1, mout);
		clk_en <= 1'b0;
		lvl <= 13'h0000;
		repeat (4) @(posedge pclk);
		chk("frozen", 1, mout);
		fork
			apb(1'b0, 4'h4, 8'h00);
			begin
				repeat (3) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		chk("stall_read", 32'h0a, rd);
		repeat (3) @(posedge pclk);
		chk("thawed", 0, mout);
		// second reset in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("mid_rst_out", 0, mout);
		apb(1'b0, 4'h0, 8'h00);
		chk("mid_rst_ctrl", 32'h20, rd);
		apb(1'b0, 4'h4, 8'h00);
		chk("mid_rst_src", 0, rd);
		results();
	end
endmodule
`default_nettype wire
